/* rtl/psb_sram_access.sv */
// Pipelined burst SRAM access logic: storage, burst counter, late write,
// byte masking, pipelined read and deselect, sleep handling.
// Assumes all pins except sleepRequest and outputDriveEnable_n are synchronous to clk_sys.
// Function
// RL1 - Read starts on qualified load with selects
// RL2 - Read data driven after the following edge
// RL3 - Output drive also needs enable pin low
// RL4 - New command accepted right after a read
// RL5 - Deselect tri-states outputs one edge later
// RL6 - Controller loads address before each burst
// RL7 - Burst counter steps two low bits, wraps
// RL8 - Order input low linear, high interleaved
// RL9 - Advance ignores selects and write select
// RL10 - Burst direction fixed at burst start
// RL11 - Interleaved order XORs start with beat
// RL12 - Linear order adds beat modulo four
// RL13 - Write starts on qualified load, selects active
// RL14 - Outputs tri-state the edge after write
// RL15 - Write data captured second edge after
// RL16 - Only selected byte lanes get written
// RL17 - Controller never drives bus against outputs
// RL18 - Controller gives lane selects every beat
// RL19 - Sleep takes two cycles in, two out
// RL20 - Access pending at sleep entry is dropped
// RL21 - Deselect before and after sleep request
// RL22 - Qualify high freezes all internal state; the sleep synchroniser still runs and sleep still clears the pipeline
// RL23 - Each lane stores data with its parity
`timescale 1ns/1ps
`default_nettype none

module psb_sram_access
	import psb_pkg::*;
#(
	parameter int ADDR_W = 21,
	parameter int LANES  = 4
)(
	input  wire logic                          clk_sys,
	input  wire logic                          reset_n,
	input  wire psb_cmd_t                      cmd,
	input  wire logic [ADDR_W-1:0]             addressIn,
	input  wire logic [LANES-1:0]              byteLaneWrite_n,
	input  wire logic                          outputDriveEnable_n,
	input  wire logic                          sleepRequest,
	input  wire logic [LANES*LANE_DATA_W-1:0]  dataIn,
	input  wire logic [LANES-1:0]              parityIoIn,
	output var  logic [LANES*LANE_DATA_W-1:0]  dataOut,
	output var  logic [LANES-1:0]              parityIoOut,
	output var  logic                          dataOe_n,
	output var  logic                          sleepActive
);

	if (ADDR_W < BURST_BITS || LANES < 1)
		$error("psb_sram_access: ADDR_W must be at least 2 and LANES at least 1");

	localparam int DEPTH = 1 << ADDR_W;

	typedef struct packed {
		logic                   drive;
		psb_lane_t [LANES-1:0]  lanes;
	} psb_word_t;

	function automatic logic [BURST_BITS-1:0] burstLow(
		input logic [BURST_BITS-1:0] start,
		input logic [BURST_BITS-1:0] beat,
		input logic                  interleaved
	);
		// Both orders stay in two bits, so the fourth step wraps by itself
		return interleaved ? (start ^ beat) : (start + beat); // see RL7 RL11 RL12
	endfunction

	// No reset on the array: contents survive reset and sleep alike
	psb_lane_t [LANES-1:0] mem [0:DEPTH-1];

	logic sleepSync1;
	logic sleepSync2;
	logic sleeping;

	logic                  burstActive;
	psb_op_t               burstOp;
	logic                  burstMode;
	logic [ADDR_W-1:0]     burstBase;
	logic [BURST_BITS-1:0] burstCnt;

	psb_op_t           s1Op;
	logic [ADDR_W-1:0] s1Addr;
	logic [LANES-1:0]  s1Mask;
	psb_op_t           s2Op;
	logic [ADDR_W-1:0] s2Addr;
	logic [LANES-1:0]  s2Mask;

	psb_word_t headWord;
	psb_word_t tailWord;
	logic      headValid;
	logic      tailValid;

	logic                  selected;
	logic                  bufInReady;
	logic                  advance;
	logic                  popReady;
	logic                  pop;
	logic [BURST_BITS-1:0] next_burstCnt;
	psb_op_t               next_op;
	logic [ADDR_W-1:0]     next_addr;
	psb_lane_t [LANES-1:0] busLanes;
	psb_word_t             readWord;

	assign selected   = !cmd.chipSelect1_n && cmd.chipSelect2 && !cmd.chipSelect3_n;
	assign bufInReady = !tailValid;
	// A full buffer stalls the pipeline just like a qualify-high edge
	assign advance    = !cmd.clockQualify_n && !sleeping && bufInReady; // see RL22
	assign popReady   = !cmd.clockQualify_n;
	assign pop        = headValid && popReady;

	// Two-flop synchroniser makes the two-cycle entry and exit
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sleepSync1 <= 1'b0;
			sleepSync2 <= 1'b0;
		end
		else
		begin
			sleepSync1 <= sleepRequest;
			sleepSync2 <= sleepSync1; // see RL19
		end
	end

	assign sleeping    = sleepSync2;
	assign sleepActive = sleeping;

	// Next command decode; an advance with no burst open stays a deselect
	always_comb
	begin
		next_burstCnt = burstCnt + BURST_STEP;
		next_op       = OP_IDLE;
		next_addr     = s1Addr;
		if (!cmd.advanceOrLoad)
		begin
			next_addr = addressIn; // see RL6
			if (selected)
				next_op = cmd.writeSelect_n ? OP_READ : OP_WRITE; // see RL1 RL13
		end
		else if (burstActive)
		begin
			// Selects and write select are not looked at here
			next_op   = burstOp; // see RL9 RL10
			next_addr = {burstBase[ADDR_W-1:BURST_BITS],
				burstLow(burstBase[BURST_BITS-1:0], next_burstCnt, burstMode)};
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			burstActive <= 1'b0;
			burstOp     <= OP_IDLE;
			burstMode   <= 1'b1;
			burstBase   <= '0;
			burstCnt    <= BURST_START;
		end
		else if (sleeping)
		begin
			burstActive <= 1'b0;
			burstOp     <= OP_IDLE;
		end
		else if (advance)
		begin
			if (!cmd.advanceOrLoad)
			begin
				burstActive <= selected;
				burstOp     <= cmd.writeSelect_n ? OP_READ : OP_WRITE; // see RL10
				burstMode   <= cmd.burstOrder; // see RL8
				burstBase   <= addressIn;
				burstCnt    <= BURST_START;
			end
			else if (burstActive)
				burstCnt <= next_burstCnt; // see RL7
		end
	end

	// Command pipeline; sleep drops whatever is in flight
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s1Op   <= OP_IDLE;
			s1Addr <= '0;
			s1Mask <= '0;
			s2Op   <= OP_IDLE;
			s2Addr <= '0;
			s2Mask <= '0;
		end
		else if (sleeping)
		begin
			s1Op <= OP_IDLE; // see RL20
			s2Op <= OP_IDLE;
		end
		else if (advance)
		begin
			s1Op   <= next_op; // see RL4
			s1Addr <= next_addr;
			s1Mask <= ~byteLaneWrite_n; // see RL18
			s2Op   <= s1Op;
			s2Addr <= s1Addr;
			s2Mask <= s1Mask;
		end
	end

	generate
		for (genvar i = 0; i < LANES; i++)
		begin : g_lane
			assign busLanes[i].data   = dataIn[i*LANE_DATA_W +: LANE_DATA_W];
			assign busLanes[i].parity = parityIoIn[i];
			assign dataOut[i*LANE_DATA_W +: LANE_DATA_W] = headWord.lanes[i].data;
			assign parityIoOut[i]                        = headWord.lanes[i].parity;
		end
	endgenerate

	// Late write: bus data is taken two edges after the command.
	// One process owns the whole array, so no lane has a second writer.
	always_ff @(posedge clk_sys)
	begin
		if (advance && s2Op == OP_WRITE)
		begin
			for (int i = 0; i < LANES; i++)
			begin
				if (s2Mask[i])
					mem[s2Addr][i] <= busLanes[i]; // see RL15 RL16 RL23
			end
		end
	end

	// A read right behind a write to the same word sees the new bytes,
	// since that write lands on the very edge the read word is loaded
	always_comb
	begin
		readWord       = '0;
		// Write beats and deselects push non-driving words
		readWord.drive = (s1Op == OP_READ); // see RL2 RL5 RL14
		for (int i = 0; i < LANES; i++)
		begin
			readWord.lanes[i] = mem[s1Addr][i];
			if (s2Op == OP_WRITE && s2Mask[i] && s2Addr == s1Addr)
				readWord.lanes[i] = busLanes[i];
		end
	end

	// Two-entry output buffer; the head is the output register.
	// The tail only fills when the head could not drain, so a stalled
	// receiver loses no word; in normal use it stays empty.
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			headValid <= 1'b0;
			tailValid <= 1'b0;
			headWord  <= '0;
			tailWord  <= '0;
		end
		else if (sleeping)
		begin
			headValid <= 1'b0;
			tailValid <= 1'b0;
		end
		else if (pop)
		begin
			if (tailValid)
			begin
				headWord  <= tailWord;
				tailValid <= 1'b0;
			end
			else if (advance)
				headWord <= readWord;
			else
				headValid <= 1'b0;
		end
		else if (advance)
		begin
			if (!headValid)
			begin
				headWord  <= readWord;
				headValid <= 1'b1;
			end
			else
			begin
				tailWord  <= readWord;
				tailValid <= 1'b1;
			end
		end
	end

	// Enable pin is combined without a clock, as on the real pin
	assign dataOe_n = !(headValid && headWord.drive && !outputDriveEnable_n && !sleeping); // see RL3

endmodule

`default_nettype wire

/* common/psb_pkg.sv */
// Shared constants and types for the pipelined burst SRAM access block.
// Assumes a single rising-edge clock domain; imported whole by the design.
package psb_pkg;

	localparam int LANE_DATA_W   = 8;
	localparam int LANE_W        = LANE_DATA_W + 1;
	localparam int BURST_LEN     = 4;
	localparam int BURST_BITS    = 2;
	localparam int CLK_PERIOD_NS = 40;
	// Sleep entry, exit and recovery are printed as whole clock periods
	localparam int SLEEP_ENTRY_CYC    = 2;
	localparam int SLEEP_EXIT_CYC     = 2;
	localparam int SLEEP_RECOVERY_CYC = 2;
	localparam int SLEEP_RECOVERY_NS  = SLEEP_RECOVERY_CYC * CLK_PERIOD_NS;

	localparam logic [BURST_BITS-1:0] BURST_START = 2'h0;
	localparam logic [BURST_BITS-1:0] BURST_STEP  = 2'h1;

	// One lane of storage: a data byte with its parity bit
	typedef struct packed {
		logic                   parity;
		logic [LANE_DATA_W-1:0] data;
	} psb_lane_t;

	typedef enum logic [2:0] {
		OP_IDLE  = 3'b001,
		OP_READ  = 3'b010,
		OP_WRITE = 3'b100
	} psb_op_t;

	// Synchronous command pins sampled together at each rising edge
	typedef struct packed {
		logic clockQualify_n;
		logic chipSelect1_n;
		logic chipSelect2;
		logic chipSelect3_n;
		logic writeSelect_n;
		logic advanceOrLoad;
		logic burstOrder;
	} psb_cmd_t;

endpackage

/* verif/psb_sram_access_properties.sv */
// Port timing checker for the SRAM access block.
// Assumes the block's top ports only; bound to it below.
`timescale 1ns/1ps
`default_nettype none
module psb_sram_access_properties
	import psb_pkg::*;
#(
	parameter int LANES = 4
)(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire psb_cmd_t cmd,
	input wire logic outputDriveEnable_n,
	input wire logic sleepRequest,
	input wire logic [LANES*LANE_DATA_W-1:0] dataOut,
	input wire logic dataOe_n,
	input wire logic sleepActive
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire logic sel = !cmd.chipSelect1_n && cmd.chipSelect2 && !cmd.chipSelect3_n;
	// Sleep edges are left out: the pipeline is dropped there
	wire logic go = !cmd.clockQualify_n && !sleepActive && !sleepRequest;
	wire logic ld = go && !cmd.advanceOrLoad;
	sequence s_rd; ld && sel && cmd.writeSelect_n ##1 go; endsequence
	sequence s_wr; ld && sel && !cmd.writeSelect_n ##1 go; endsequence
	sequence s_ds; ld && !sel ##1 go; endsequence
	property p_read; s_rd |=> outputDriveEnable_n || !dataOe_n; endproperty
	property p_wrOff; s_wr |=> dataOe_n; endproperty
	property p_desel; s_ds |=> dataOe_n; endproperty
	property p_oe; outputDriveEnable_n |-> dataOe_n; endproperty
	property p_sleepOff; sleepActive |-> dataOe_n; endproperty
	property p_sleepIn; sleepRequest [*2] |=> sleepActive; endproperty
	property p_sleepOut; !sleepRequest [*2] |=> !sleepActive; endproperty
	property p_stall; cmd.clockQualify_n && !sleepRequest && !sleepActive |=> $stable(dataOut);
	endproperty
	a_read: assert property (p_read) else $error("read not driven");
	a_wrOff: assert property (p_wrOff) else $error("write not tri");
	a_desel: assert property (p_desel) else $error("deselect not tri");
	a_oe: assert property (p_oe) else $error("drive without enable");
	a_sleepOff: assert property (p_sleepOff) else $error("drive in sleep");
	a_sleepIn: assert property (p_sleepIn) else $error("sleep entry late");
	a_sleepOut: assert property (p_sleepOut) else $error("sleep exit late");
	a_stall: assert property (p_stall) else $error("stall moved data");
endmodule
bind psb_sram_access psb_sram_access_properties #(.LANES(LANES)) psb_props_i (.clk_sys,
	.reset_n, .cmd, .outputDriveEnable_n, .sleepRequest, .dataOut, .dataOe_n, .sleepActive);
`default_nettype wire

/* verif/psb_ctrl_model.sv */
// Controller side of the shared data and parity bus.
// Assumes four lanes; the bench tells it when to drive.
`timescale 1ns/1ps
`default_nettype none
module psb_ctrl_model
	import psb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [35:0] devOut,
	input wire logic dataOe_n,
	input wire logic drvEn,
	input wire logic [35:0] drvData,
	output var logic [35:0] bus,
	output var logic clash
);
	logic [35:0] last = '0;
	// A released bus changes every cycle, so stale words never pass
	always_comb
	begin
		if (!dataOe_n)
			bus = devOut;
		else if (drvEn)
			bus = drvData;
		else
			bus = ~last;
	end
	always_ff @(posedge clk_sys)
		last <= bus;
	assign clash = drvEn && !dataOe_n;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the SRAM access block.
// Assumes a 6-bit address so the scoreboard memory stays small.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import psb_pkg::*;
();
	logic clk_sys = 0, reset_n = 0, oeN = 0, sleepRequest = 0, drvEn = 0;
	logic clash, dataOe_n, sleepActive;
	psb_cmd_t cmd = 7'h6d;
	logic [5:0] addressIn = '0;
	logic [3:0] byteLaneWrite_n = '1, parityIoOut;
	logic [31:0] dataOut;
	logic [35:0] drvData = '0, bus;
	logic [35:0] mem [64], sv [2];
	int sk [2] = '{0, 0};
	int err_count = 0, n_tests = 0;
	always #20 clk_sys = ~clk_sys;
	psb_sram_access #(.ADDR_W(6)) psb_sram_access_i (.clk_sys, .reset_n, .cmd, .addressIn,
		.byteLaneWrite_n, .outputDriveEnable_n(oeN), .sleepRequest, .dataIn(bus[31:0]),
		.parityIoIn(bus[35:32]), .dataOut, .parityIoOut, .dataOe_n, .sleepActive);
	psb_ctrl_model psb_ctrl_model_i (.clk_sys, .devOut({parityIoOut, dataOut}), .dataOe_n,
		.drvEn, .drvData, .bus, .clash);
	task summarize();
		if (err_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [35:0] got, input logic [35:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	always @(negedge clk_sys)
		if (clash !== 1'b0)
			chk(clash, 0);
	// k: 0 deselect, 1 load, 2 advance, 3 stall; checks the op two advancing edges back
	task op(input int k, input bit w, input logic [5:0] a, input logic [3:0] m,
		input logic [35:0] d);
		if (sk[1] != 0)
			chk(dataOe_n, (sk[1] == 1) ? oeN : 1'b1);
		if (sk[1] == 1 && !oeN)
			chk({parityIoOut, dataOut}, sv[1]);
		drvEn = (sk[1] == 2);
		drvData = sv[1];
		cmd.clockQualify_n = (k == 3);
		cmd.advanceOrLoad = (k == 2);
		{cmd.chipSelect1_n, cmd.chipSelect2, cmd.chipSelect3_n} = (k == 1) ? 3'h2 : 3'h5;
		cmd.writeSelect_n = (k == 2) ? w : !w;
		addressIn = (k == 2) ? ~a : a;
		byteLaneWrite_n = ~m;
		if (k != 3)
		begin
			sk[1] = sk[0];
			sv[1] = sv[0];
			sk[0] = (k == 0) ? 3 : w ? 2 : 1;
			sv[0] = w ? d : mem[a];
			for (int i = 0; i < 4; i++)
				if (w && m[i])
				begin
					mem[a][8*i+:8] = d[8*i+:8];
					mem[a][32+i] = d[32+i];
				end
		end
		@(posedge clk_sys) #1;
	endtask
	task t_single();
		op(1, 1, 5, 4'hf, 36'h1_2345_6789);
		op(1, 1, 5, 4'h5, 36'ha_aaaa_bbbb);
		op(1, 0, 5, 0, 0);
		op(3, 0, 5, 0, 0);
		op(1, 0, 5, 0, 0);
		repeat (2) op(0, 0, 0, 0, 0);
	endtask
	task t_oe();
		oeN = 1;
		op(1, 0, 5, 0, 0);
		repeat (2) op(0, 0, 0, 0, 0);
		oeN = 0;
	endtask
	task t_burst(input bit o, input logic [1:0] s);
		logic [5:0] a;
		cmd.burstOrder = o;
		for (int r = 0; r < 2; r++)
			for (int k = 0; k < 4; k++)
			begin
				a = {4'h4, o ? s ^ k[1:0] : s + k[1:0]};
				op(k ? 2 : 1, !r, a, 4'hf, {30'(k + 7), a});
			end
		repeat (2) op(0, 0, 0, 0, 0);
	endtask
	task t_sleep();
		sleepRequest = 1;
		@(posedge clk_sys) #1;
		chk(sleepActive, 0);
		@(posedge clk_sys) #1;
		chk(sleepActive, 1);
		sleepRequest = 0;
		repeat (2) @(posedge clk_sys) #1;
		chk(sleepActive, 0);
		repeat (2) op(0, 0, 0, 0, 0);
		op(1, 0, 5, 0, 0);
		repeat (2) op(0, 0, 0, 0, 0);
	endtask
	initial
	begin
		#(40 * 3000);
		err_count++;
		summarize();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		#1 reset_n = 1;
		t_single();
		t_oe();
		for (int o = 0; o < 2; o++)
			for (int s = 0; s < 4; s++)
				t_burst(o[0], s[1:0]);
		t_sleep();
		summarize();
	end
endmodule
`default_nettype wire
